// *** rtl/ptpdit_pkg.sv ***
// Package: register map, field layout and reset values of the PTP index and trigger status bank
package ptpdit_pkg;
  localparam logic [11:0] VERSION_DOMAIN_OFFSET = 12'h518;
  localparam logic [11:0] UNIT_SELECT_OFFSET = 12'h520;
  localparam logic [11:0] TRIG_STATUS_OFFSET = 12'h524;
  localparam logic [11:0] DOMAIN_CHECK_OFFSET = 12'h5C0;
  localparam logic [11:0] TRIG_CONTROL_OFFSET = 12'h5C4;
  localparam logic [11:0] WINDOW_LOW = 12'h52C;
  localparam logic [11:0] WINDOW_HIGH = 12'h5B3;
  localparam int VERSION_LSB = 8;
  localparam int DOMAIN_LSB = 0;
  localparam int STAMP_SEL_BIT = 8;
  localparam int TRIG_SEL_LSB = 0;
  localparam int TRIG_ERROR_LSB = 16;
  localparam int TRIG_DONE_LSB = 0;
  localparam int NOTIFY_LSB = 8;
  localparam int TRIG_EN_LSB = 0;
  localparam int TRIG_UNITS = 3;
  localparam logic [3:0] VERSION_RESET = 4'h2;
  localparam logic [7:0] DOMAIN_RESET = 8'h00;
  localparam logic STAMP_SEL_RESET = 1'b0;
  localparam logic [1:0] TRIG_SEL_RESET = 2'h0;
  localparam logic [1:0] TRIG_SEL_RESERVED = 2'h3;
  localparam logic [2:0] TRIG_FLAGS_RESET = 3'h0;
  localparam logic DOMAIN_CHECK_RESET = 1'b0;

  typedef enum logic [2:0] {
    PTPDIT_IDLE = 3'b001,
    PTPDIT_CHECK = 3'b010,
    PTPDIT_DONE = 3'b100
  } ptpdit_rx_state_t;
endpackage

// *** rtl/ptpdit_rx_if.sv ***
// Interface: received message header fields and filter verdict
`timescale 1ns/1ps
interface ptpdit_rx_if;
  logic msg_valid;
  logic [3:0] msg_version;
  logic [7:0] msg_domain;
  logic [3:0] expected_version;
  logic [7:0] expected_domain_number;
  logic domain_check_en;
  logic verdict_valid;
  logic capture;
  logic forward_host;
  modport bank (output msg_valid, output msg_version, output msg_domain, output expected_version,
    output expected_domain_number, output domain_check_en, input verdict_valid, input capture, input forward_host);
  modport filter (input msg_valid, input msg_version, input msg_domain, input expected_version,
    input expected_domain_number, input domain_check_en, output verdict_valid, output capture, output forward_host);
endinterface

// *** rtl/ptpdit_msg_filter.sv ***
// Received time-protocol message filter on version and domain
`timescale 1ns/1ps
module ptpdit_msg_filter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  ptpdit_rx_if.filter rx
);
  typedef struct packed {
    ptpdit_pkg::ptpdit_rx_state_t state;
    logic [3:0] version;
    logic [7:0] domain;
    logic verdict_valid;
    logic capture;
    logic forward_host;
  } ptpdit_filter_t;

  ptpdit_filter_t cur;
  ptpdit_filter_t next_cur;
  logic version_ok;
  logic domain_ok;

  always_comb begin
    next_cur = cur;
    next_cur.verdict_valid = 1'b0;
    version_ok = (cur.version == rx.expected_version);
    domain_ok = !rx.domain_check_en || (cur.domain == rx.expected_domain_number);
    case (cur.state)
      ptpdit_pkg::PTPDIT_IDLE: begin
        if (rx.msg_valid) begin
          next_cur.version = rx.msg_version;
          next_cur.domain = rx.msg_domain;
          next_cur.state = ptpdit_pkg::PTPDIT_CHECK;
        end
      end
      ptpdit_pkg::PTPDIT_CHECK: begin
        next_cur.capture = version_ok && domain_ok;
        next_cur.forward_host = version_ok && domain_ok;
        next_cur.verdict_valid = 1'b1;
        next_cur.state = ptpdit_pkg::PTPDIT_DONE;
      end
      ptpdit_pkg::PTPDIT_DONE: begin
        next_cur.state = ptpdit_pkg::PTPDIT_IDLE;
      end
      default: begin
        next_cur.state = ptpdit_pkg::PTPDIT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cur <= '{state: ptpdit_pkg::PTPDIT_IDLE, version: 4'h0, domain: 8'h00,
        verdict_valid: 1'b0, capture: 1'b0, forward_host: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign rx.verdict_valid = cur.verdict_valid;
  assign rx.capture = cur.capture;
  assign rx.forward_host = cur.forward_host;
endmodule

// *** rtl/ptpdit_bank.sv ***
// Top: PTP version/domain, unit index and trigger status register bank
// Functional notes
// - A four-bit expected version in bits 11:8 resets to 0x2 and messages with that version are captured when the domain check passes.
// - Messages whose version differs from the expected version are discarded.
// - With domain checking on, capture needs the message domain to equal the eight-bit domain in bits 7:0.
// - With domain checking off, the message domain plays no part in capture.
// - With domain checking on, a matching message goes to the host port and a mismatching one is dropped.
// - Accesses from 0x052C to 0x05B3 reach only the timestamp and trigger units chosen by the index register.
// - Bit 8 of the index register picks timestamp unit 0 or 1 and resets to zero.
// - Bits 1:0 pick trigger unit 0, 1 or 2, reset to 00, and code 11 is reserved.
// - A notifying trigger unit whose time is already past sets its error flag in bits 18:16 and interrupts.
// - A unit's error flag also clears when software writes zero to that unit's trigger enable.
// - A notifying trigger unit sets its done flag in bits 2:0 when its output is made; writing one clears it.
// - Status flags reset to 000b and reserved bits 31:19 and 15:3 read zero and ignore writes.
`timescale 1ns/1ps
module ptpdit_bank (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic msg_valid_i,
  input wire logic [3:0] msg_version_i,
  input wire logic [7:0] msg_domain_i,
  output logic verdict_valid_o,
  output logic capture_o,
  output logic forward_host_o,
  input wire logic [2:0] trig_done_event_i,
  input wire logic [2:0] trig_late_event_i,
  output logic [2:0] trig_enable_o,
  output logic [2:0] trig_irq_request_o,
  output logic [1:0] trig_unit_select_o,
  output logic stamp_unit_select_o,
  output logic window_wr_o,
  output logic window_rd_o,
  output logic [11:0] window_addr_o,
  output logic [31:0] window_wdata_o,
  input wire logic [31:0] window_rdata_i,
  output logic trig_irq_o
);
  typedef struct packed {
    logic [3:0] expected_version;
    logic [7:0] expected_domain_number;
    logic domain_check_en;
    logic stamp_unit_select;
    logic [1:0] trig_unit_select;
    logic [2:0] trig_error;
    logic [2:0] trig_done;
    logic [2:0] trig_enable;
    logic [2:0] trig_irq_request;
    logic window_wr;
    logic window_rd;
    logic [11:0] window_addr;
    logic [31:0] window_wdata;
    logic window_rd_pending;
    logic [31:0] rdata;
    logic irq;
  } ptpdit_bank_t;

  ptpdit_bank_t cur;
  ptpdit_bank_t next_cur;
  ptpdit_rx_if rx_bus ();

  function automatic logic in_window(input logic [11:0] a);
    in_window = (a >= ptpdit_pkg::WINDOW_LOW) && (a <= ptpdit_pkg::WINDOW_HIGH);
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
    hit = (a[11:2] == base[11:2]);
  endfunction

  assign rx_bus.msg_valid = msg_valid_i;
  assign rx_bus.msg_version = msg_version_i;
  assign rx_bus.msg_domain = msg_domain_i;
  assign rx_bus.expected_version = cur.expected_version;
  assign rx_bus.expected_domain_number = cur.expected_domain_number;
  assign rx_bus.domain_check_en = cur.domain_check_en;

  ptpdit_msg_filter u_filter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .rx(rx_bus)
  );

  always_comb begin
    logic [2:0] err_clear;
    logic [2:0] done_clear;
    logic [2:0] new_enable;
    err_clear = 3'h0;
    done_clear = 3'h0;
    new_enable = cur.trig_enable;
    next_cur = cur;
    next_cur.window_wr = 1'b0;
    next_cur.window_rd = 1'b0;
    next_cur.window_rd_pending = 1'b0;
    next_cur.rdata = 32'h0000_0000;
    if (wr_i) begin
      if (hit(addr_i, ptpdit_pkg::VERSION_DOMAIN_OFFSET)) begin
        next_cur.expected_version = wdata_i[ptpdit_pkg::VERSION_LSB +: 4];
        next_cur.expected_domain_number = wdata_i[ptpdit_pkg::DOMAIN_LSB +: 8];
      end
      if (hit(addr_i, ptpdit_pkg::UNIT_SELECT_OFFSET)) begin
        next_cur.stamp_unit_select = wdata_i[ptpdit_pkg::STAMP_SEL_BIT];
        next_cur.trig_unit_select = wdata_i[ptpdit_pkg::TRIG_SEL_LSB +: 2];
      end
      if (hit(addr_i, ptpdit_pkg::TRIG_STATUS_OFFSET)) begin
        err_clear = wdata_i[ptpdit_pkg::TRIG_ERROR_LSB +: 3];
        done_clear = wdata_i[ptpdit_pkg::TRIG_DONE_LSB +: 3];
      end
      if (hit(addr_i, ptpdit_pkg::DOMAIN_CHECK_OFFSET)) begin
        next_cur.domain_check_en = wdata_i[0];
      end
      if (hit(addr_i, ptpdit_pkg::TRIG_CONTROL_OFFSET)) begin
        new_enable = wdata_i[ptpdit_pkg::TRIG_EN_LSB +: 3];
        next_cur.trig_irq_request = wdata_i[ptpdit_pkg::NOTIFY_LSB +: 3];
        err_clear = err_clear | ~new_enable;
      end
      if (in_window(addr_i)) begin
        next_cur.window_wr = 1'b1;
        next_cur.window_addr = addr_i;
        next_cur.window_wdata = wdata_i;
      end
    end
    next_cur.trig_enable = new_enable;
    // Set beats clear; events only count while notify is on
    next_cur.trig_error = (cur.trig_error & ~err_clear) |
      (trig_late_event_i & cur.trig_irq_request);
    next_cur.trig_done = (cur.trig_done & ~done_clear) |
      (trig_done_event_i & cur.trig_irq_request);
    next_cur.irq = |next_cur.trig_error || |next_cur.trig_done;
    if (rd_i) begin
      if (in_window(addr_i)) begin
        next_cur.window_rd = 1'b1;
        next_cur.window_addr = addr_i;
        next_cur.window_rd_pending = 1'b1;
      end else if (hit(addr_i, ptpdit_pkg::VERSION_DOMAIN_OFFSET)) begin
        next_cur.rdata[ptpdit_pkg::VERSION_LSB +: 4] = cur.expected_version;
        next_cur.rdata[ptpdit_pkg::DOMAIN_LSB +: 8] = cur.expected_domain_number;
      end else if (hit(addr_i, ptpdit_pkg::UNIT_SELECT_OFFSET)) begin
        next_cur.rdata[ptpdit_pkg::STAMP_SEL_BIT] = cur.stamp_unit_select;
        next_cur.rdata[ptpdit_pkg::TRIG_SEL_LSB +: 2] = cur.trig_unit_select;
      end else if (hit(addr_i, ptpdit_pkg::TRIG_STATUS_OFFSET)) begin
        next_cur.rdata[ptpdit_pkg::TRIG_ERROR_LSB +: 3] = cur.trig_error;
        next_cur.rdata[ptpdit_pkg::TRIG_DONE_LSB +: 3] = cur.trig_done;
      end else if (hit(addr_i, ptpdit_pkg::DOMAIN_CHECK_OFFSET)) begin
        next_cur.rdata[0] = cur.domain_check_en;
      end else if (hit(addr_i, ptpdit_pkg::TRIG_CONTROL_OFFSET)) begin
        next_cur.rdata[ptpdit_pkg::TRIG_EN_LSB +: 3] = cur.trig_enable;
        next_cur.rdata[ptpdit_pkg::NOTIFY_LSB +: 3] = cur.trig_irq_request;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cur <= '{expected_version: ptpdit_pkg::VERSION_RESET,
        expected_domain_number: ptpdit_pkg::DOMAIN_RESET,
        domain_check_en: ptpdit_pkg::DOMAIN_CHECK_RESET,
        stamp_unit_select: ptpdit_pkg::STAMP_SEL_RESET,
        trig_unit_select: ptpdit_pkg::TRIG_SEL_RESET,
        trig_error: ptpdit_pkg::TRIG_FLAGS_RESET,
        trig_done: ptpdit_pkg::TRIG_FLAGS_RESET,
        trig_enable: 3'h0, trig_irq_request: 3'h0,
        window_wr: 1'b0, window_rd: 1'b0, window_addr: 12'h000,
        window_wdata: 32'h0000_0000, window_rd_pending: 1'b0,
        rdata: 32'h0000_0000, irq: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // Window reads answer a cycle after rd_i, in the window_rd_o strobe cycle, from the selected unit
  always_comb begin
    rdata_o = cur.window_rd_pending ? window_rdata_i : cur.rdata;
  end

  assign verdict_valid_o = rx_bus.verdict_valid;
  assign capture_o = rx_bus.capture;
  assign forward_host_o = rx_bus.forward_host;
  assign trig_enable_o = cur.trig_enable;
  assign trig_irq_request_o = cur.trig_irq_request;
  assign trig_unit_select_o = cur.trig_unit_select;
  assign stamp_unit_select_o = cur.stamp_unit_select;
  assign window_wr_o = cur.window_wr;
  assign window_rd_o = cur.window_rd;
  assign window_addr_o = cur.window_addr;
  assign window_wdata_o = cur.window_wdata;
  assign trig_irq_o = cur.irq;
endmodule

// *** verif/ptpdit_bank_checker.sv ***
// Checker: bus, window, filter and trigger flag relations of the PTP bank
`timescale 1ns/1ps
module ptpdit_bank_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic msg_valid_i,
  input wire logic verdict_valid_o,
  input wire logic capture_o,
  input wire logic forward_host_o,
  input wire logic [2:0] trig_done_event_i,
  input wire logic [2:0] trig_irq_request_o,
  input wire logic [1:0] trig_unit_select_o,
  input wire logic stamp_unit_select_o,
  input wire logic window_wr_o,
  input wire logic window_rd_o,
  input wire logic [11:0] window_addr_o,
  input wire logic [31:0] window_rdata_i,
  input wire logic trig_irq_o
);
  logic in_win;
  logic [31:0] wd_q;
  assign in_win = addr_i >= ptpdit_pkg::WINDOW_LOW && addr_i <= ptpdit_pkg::WINDOW_HIGH;
  always_ff @(posedge clk_i) begin
    wd_q <= wdata_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_verdict_delay: assert property (verdict_valid_o |-> $past(msg_valid_i, 2))
    else $error("verdict without a message two cycles before");
  chk_forward_same: assert property (verdict_valid_o |-> forward_host_o == capture_o)
    else $error("forward and capture differ");
  chk_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  chk_window_write: assert property (wr_i && in_win |=> window_wr_o && window_addr_o == $past(addr_i))
    else $error("window write not passed on");
  chk_window_skip: assert property ((wr_i || rd_i) && !in_win |=> !window_wr_o && !window_rd_o)
    else $error("access outside window reached a unit");
  chk_window_read: assert property (rd_i && in_win |=> window_rd_o && rdata_o == window_rdata_i)
    else $error("window read data wrong");
  chk_select_write: assert property (wr_i && addr_i[11:2] == ptpdit_pkg::UNIT_SELECT_OFFSET[11:2]
    |=> trig_unit_select_o == wd_q[1:0] && stamp_unit_select_o == wd_q[8])
    else $error("unit select not updated");
  chk_done_irq: assert property (|(trig_done_event_i & trig_irq_request_o) |=> trig_irq_o)
    else $error("done event raised no interrupt");
  chk_notify_gate: assert property (!trig_irq_o && trig_irq_request_o == 3'h0 |=> !trig_irq_o)
    else $error("interrupt without notify");
  cover property (verdict_valid_o && capture_o);
  cover property ($rose(trig_irq_o));
  cover property (window_rd_o);
endmodule

// *** verif/ptpdit_bank_bench.sv ***
// Bench: register rows, filter, window and trigger flag tests for the PTP bank
`timescale 1ns/1ps
module ptpdit_bank_bench;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} ptpdit_row_t;
  ptpdit_row_t rows [6] = '{'{12'h518, 32'hFFFFFFFF, 32'h00000FFF}, '{12'h518, 32'h00000A5C, 32'h00000A5C},
    '{12'h520, 32'hFFFFFFFF, 32'h00000103}, '{12'h520, 32'h00000102, 32'h00000102},
    '{12'h524, 32'hFFFFFFFF, 32'h0}, '{12'h600, 32'hFFFFFFFF, 32'h0}};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] addr_i = 12'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0, rd_i = 1'b0, msg_valid_i = 1'b0;
  logic [3:0] msg_version_i = 4'h0;
  logic [7:0] msg_domain_i = 8'h0;
  logic [2:0] trig_done_event_i = 3'h0, trig_late_event_i = 3'h0;
  logic [31:0] window_rdata_i = 32'hCAFE0001;
  logic [31:0] rdata_o, window_wdata_o;
  logic [11:0] window_addr_o;
  logic [2:0] trig_enable_o, trig_irq_request_o;
  logic [1:0] trig_unit_select_o;
  logic verdict_valid_o, capture_o, forward_host_o, stamp_unit_select_o, window_wr_o, window_rd_o, trig_irq_o;
  int n_errors = 0, total_checks = 0;
  always #12.5 clk_i = ~clk_i;
  ptpdit_bank i_dut (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic msg(input logic [3:0] v, input logic [7:0] d, input logic exp);
    @(posedge clk_i);
    msg_version_i <= v;
    msg_domain_i <= d;
    msg_valid_i <= 1'b1;
    @(posedge clk_i);
    msg_valid_i <= 1'b0;
    @(posedge clk_i);
    #1 chk({29'h0, verdict_valid_o, capture_o, forward_host_o}, {29'h1, exp, exp});
  endtask
  task automatic pulse(input logic [2:0] d, input logic [2:0] l);
    @(posedge clk_i);
    trig_done_event_i <= d;
    trig_late_event_i <= l;
    @(posedge clk_i);
    trig_done_event_i <= 3'h0;
    trig_late_event_i <= 3'h0;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    report_and_stop();
  end
  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("Register rows done");
    wr(12'h518, 32'h00000233);
    wr(12'h5C0, 32'h1);
    msg(4'h2, 8'h33, 1'b1);
    msg(4'h3, 8'h33, 1'b0);
    msg(4'h2, 8'h34, 1'b0);
    wr(12'h5C0, 32'h0);
    msg(4'h2, 8'h99, 1'b1);
    msg(4'h5, 8'h99, 1'b0);
    $display("Filter done");
    wr(12'h520, 32'h00000101);
    #1 chk({29'h0, stamp_unit_select_o, trig_unit_select_o}, 32'h5);
    wr(12'h5B0, 32'h00001234);
    #1 chk({19'h0, window_wr_o, window_addr_o}, {19'h0, 1'b1, 12'h5B0});
    chk(window_wdata_o, 32'h00001234);
    rd(12'h52C, 32'hCAFE0001);
    rd(12'h528, 32'h0);
    rd(12'h5B4, 32'h0);
    $display("Window done");
    wr(12'h5C4, 32'h00000707);
    #1 chk({21'h0, trig_irq_request_o, 5'h0, trig_enable_o}, 32'h00000707);
    pulse(3'h2, 3'h0);
    rd(12'h524, 32'h2);
    chk({31'h0, trig_irq_o}, 32'h1);
    wr(12'h524, 32'h0);
    rd(12'h524, 32'h2);
    wr(12'h524, 32'h2);
    rd(12'h524, 32'h0);
    chk({31'h0, trig_irq_o}, 32'h0);
    @(posedge clk_i);
    addr_i <= 12'h524;
    wdata_i <= 32'h1;
    wr_i <= 1'b1;
    trig_done_event_i <= 3'h1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    trig_done_event_i <= 3'h0;
    rd(12'h524, 32'h1);
    wr(12'h524, 32'h1);
    pulse(3'h0, 3'h4);
    rd(12'h524, 32'h00040000);
    wr(12'h5C4, 32'h00000703);
    rd(12'h524, 32'h0);
    wr(12'h5C4, 32'h00000007);
    pulse(3'h7, 3'h7);
    rd(12'h524, 32'h0);
    $display("Trigger flags done");
    wr(12'h5C4, 32'h00000100);
    pulse(3'h1, 3'h0);
    @(posedge clk_i);
    do_reset();
    rd(12'h518, 32'h00000200);
    rd(12'h520, 32'h0);
    rd(12'h524, 32'h0);
    chk({31'h0, trig_irq_o}, 32'h0);
    $display("Reset done");
    report_and_stop();
  end
endmodule
bind ptpdit_bank ptpdit_bank_checker i_chk (.*);
